//--- line_sense_pkg.sv
// shared constants and state carrier for the line sense and hook control
package line_sense_pkg;
  // register numbers on the serial control link
  localparam logic [7:0] REG_IRQ_CTL = 8'h02;
  localparam logic [7:0] REG_IRQ_MASK = 8'h03;
  localparam logic [7:0] REG_IRQ_FLAG = 8'h04;
  localparam logic [7:0] REG_HOOK = 8'h05;
  localparam logic [7:0] REG_COARSE = 8'h0C;
  localparam logic [7:0] REG_ADC_CAL = 8'h11;
  localparam logic [7:0] REG_LINE_STAT = 8'h13;
  localparam logic [7:0] REG_RES_CAL = 8'h19;
  localparam logic [7:0] REG_DC_CTL = 8'h1A;
  localparam logic [7:0] REG_FINE = 8'h1C;
  localparam logic [7:0] REG_VOLT = 8'h1D;
  localparam logic [7:0] REG_SETTLE = 8'h1F;
  localparam logic [7:0] REG_GND_START = 8'h20;
  // field positions
  localparam int B_IRQ_PIN_ENABLE = 7;
  localparam int B_IRQ_PIN_POLARITY = 6;
  localparam int B_POL = 0;
  localparam int B_TG = 1;
  localparam int B_MAXI = 2;
  localparam int B_HOOK = 0;
  localparam int B_ADC_CAL_DISABLE = 5;
  localparam int B_OVC = 0;
  localparam int B_DROP = 1;
  localparam int B_RESISTOR_CAL_DISABLE = 5;
  localparam int B_CURRENT_LIMIT_MODE = 1;
  localparam int B_FOH_LO = 5;
  localparam int B_LOW_VOLTAGE_ZERO_FORCE_DISABLE = 0;
  localparam int B_RG = 0;
  localparam int B_TIP_RELAY_OPEN = 1;
  localparam int B_TGD = 2;
  // reset values
  localparam logic [1:0] FOH_RESET = 2'h1;
  localparam logic RG_RESET = 1'b0;
  localparam logic TIP_RELAY_OPEN_RESET = 1'b0;
  // measurement scaling
  localparam int unsigned LV_ZERO_V = 3;
  localparam int unsigned FINE_LSB_TENTH_MA = 11;
  localparam int unsigned COARSE_PER_FINE = 3;
  localparam logic [4:0] COARSE_MAX = 5'h1F;
  localparam int unsigned OC_HI_MA = 160;
  localparam int unsigned OC_LO_MA = 60;
  localparam logic [7:0] OC_HI_CODE = 8'((OC_HI_MA * 10) / FINE_LSB_TENTH_MA);
  localparam logic [7:0] OC_LO_CODE = 8'((OC_LO_MA * 10) / FINE_LSB_TENTH_MA);
  // timing
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned CLK_NS = 8;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int unsigned LATENCY_US = 250;
  localparam int unsigned SETTLE_8_MS = 8;
  localparam int unsigned SETTLE_64_MS = 64;
  localparam int unsigned SETTLE_128_MS = 128;
  localparam int unsigned SETTLE_512_MS = 512;
  localparam int unsigned RCAL_MS = 17;
  localparam int unsigned ADCCAL_MS = 256;
  localparam int unsigned US_PER_MS = 1000;
  localparam int CNT_W = 20;

  typedef enum logic [5:0] {
    ST_ONHOOK = 6'h01,
    ST_LATENCY = 6'h02,
    ST_SETTLE = 6'h04,
    ST_RCAL = 6'h08,
    ST_ADCCAL = 6'h10,
    ST_ACTIVE = 6'h20
  } hook_state_e;

  typedef struct packed {
    logic irq_pin_enable;
    logic irq_pin_polarity;
    logic polarity_change_mask;
    logic tip_ground_mask;
    logic maxm;
    logic polFlag;
    logic tgFlag;
    logic maxFlag;
    logic hook;
    logic adc_cal_disable;
    logic resistor_cal_disable;
    logic current_limit_mode;
    logic [1:0] offhook_settle_select;
    logic low_voltage_zero_force_disable;
    logic ringGnd;
    logic tipOpen;
    logic [7:0] vSync1;
    logic [7:0] vSync2;
    logic [7:0] iSync1;
    logic [7:0] iSync2;
    logic tSync1;
    logic tSync2;
    logic tipSeen;
    logic [7:0] lineVolt;
    logic [7:0] fine;
    logic [4:0] coarse;
    logic overCur;
    logic dropout;
    hook_state_e state;
    logic [CNT_W-1:0] cnt;
    logic [7:0] rdData;
  } sense_state_s;
endpackage

//--- us_tick_divider.sv
// divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
module us_tick_divider #(
  parameter int unsigned DIV = 125
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // enable pulse
  output logic tick
);
  logic [15:0] cnt_q;

  initial begin
    if (DIV < 1 || DIV > 65536) $error("divider ratio out of range");
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q == 16'(DIV - 1)) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign tick = (cnt_q == 16'(DIV - 1));
endmodule

//--- line_sense_hook_control.sv
// line voltage and loop current sensing with off-hook sequencing
// Notes on behaviour
// - signed 8-bit line voltage, one volt per count, always valid
// - top bit of the voltage field gives tip/ring polarity
// - pin enable plus polarity mask interrupt on each sign toggle
// - polarity flag set on every sign toggle, held until written zero
// - voltage field forced to zero at three volts or less by default
// - disable bit stops that forcing so small readings show
// - zero volts reads all zeros; zero to two volts may be unpredictable
// - coarse five-bit loop current at 3.3 mA per count while off-hook
// - fine eight-bit loop current at 1.1 mA per count while off-hook
// - coarse 0 too little, 4 minimum, all ones possibly excessive
// - maximum-current flag set when coarse current reaches all ones
// - overcurrent above 160 mA, or above 60 mA in limit mode
// - writing one to hook bit reaches line side after 250 us
// - after off-hook, traffic blocked for 8, 64, 128 or 512 ms
// - then 17 ms resistor calibration unless disabled
// - then 256 ms converter calibration unless disabled
// - tip-ground sensed bit follows the detector without latching
// - tip-ground flag latched at current onset, interrupts if masked in
// - interrupt held while any enabled flag stays set
// - interrupt active low unless polarity bit set
`timescale 1ns/1ps
module line_sense_hook_control #(
  parameter int unsigned TICK_CYCLES = line_sense_pkg::TICK_CYCLES,
  parameter int unsigned LATENCY_US = line_sense_pkg::LATENCY_US,
  parameter int unsigned MS_US = line_sense_pkg::US_PER_MS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register access from the serial control link
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // line-side measurements, asynchronous
  input wire logic [7:0] lineVoltSample,
  input wire logic [7:0] loopCurrentSample,
  input wire logic tipCurrentDetect,
  // line-side hook and traffic control
  output logic lineOffHook,
  output logic txRxBlocked,
  output logic resCalActive,
  output logic adcCalActive,
  // ground-start relays
  output logic tipRelayOpen,
  output logic ringGroundRelayCtl,
  // open-drain interrupt pin
  output logic irqOut,
  output logic irqOe
);
  localparam int CNT_W_L = line_sense_pkg::CNT_W;

  line_sense_pkg::sense_state_s st_q;
  line_sense_pkg::sense_state_s st_d;
  logic tick;
  logic [8:0] vMag;
  logic [7:0] coarseFull;
  logic [7:0] ocCode;
  logic irqActive;
  logic wrFlag;
  logic [CNT_W_L-1:0] target;

  initial begin
    if (TICK_CYCLES < 1) $error("tick ratio must be at least one");
    if (LATENCY_US < 1 || MS_US < 1) $error("timing must be at least one");
    if (line_sense_pkg::SETTLE_512_MS * MS_US >= (1 << CNT_W_L))
      $error("settle count overflows the counter");
  end

  us_tick_divider #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick)
  );

  // magnitude of the synchronised voltage sample, 9 bits to hold -128
  always_comb begin
    if (st_q.vSync2[7]) begin
      vMag = 9'h000 - {1'b1, st_q.vSync2};
    end else begin
      vMag = {1'b0, st_q.vSync2};
    end
  end

  assign coarseFull = st_q.iSync2 / 8'(line_sense_pkg::COARSE_PER_FINE);
  assign ocCode = st_q.current_limit_mode ? line_sense_pkg::OC_LO_CODE
                            : line_sense_pkg::OC_HI_CODE;
  assign wrFlag = regWrEn && regAddr == line_sense_pkg::REG_IRQ_FLAG;

  // phase length in microsecond ticks for the current state
  always_comb begin
    target = CNT_W_L'(LATENCY_US);
    case (st_q.state)
      line_sense_pkg::ST_SETTLE: begin
        case (st_q.offhook_settle_select)
          2'h0: target = CNT_W_L'(line_sense_pkg::SETTLE_512_MS * MS_US);
          2'h1: target = CNT_W_L'(line_sense_pkg::SETTLE_128_MS * MS_US);
          2'h2: target = CNT_W_L'(line_sense_pkg::SETTLE_64_MS * MS_US);
          default: target = CNT_W_L'(line_sense_pkg::SETTLE_8_MS * MS_US);
        endcase
      end
      line_sense_pkg::ST_RCAL: begin
        target = CNT_W_L'(line_sense_pkg::RCAL_MS * MS_US);
      end
      line_sense_pkg::ST_ADCCAL: begin
        target = CNT_W_L'(line_sense_pkg::ADCCAL_MS * MS_US);
      end
      default: begin
        target = CNT_W_L'(LATENCY_US);
      end
    endcase
  end

  always_comb begin
    st_d = st_q;
    // two-flop synchronisers on line-side inputs
    st_d.vSync1 = lineVoltSample;
    st_d.vSync2 = st_q.vSync1;
    st_d.iSync1 = loopCurrentSample;
    st_d.iSync2 = st_q.iSync1;
    st_d.tSync1 = tipCurrentDetect;
    st_d.tSync2 = st_q.tSync1;
    st_d.tipSeen = st_q.tSync2;

    // signed volts field; small readings forced to zero unless disabled
    if (!st_q.low_voltage_zero_force_disable && vMag <= 9'(line_sense_pkg::LV_ZERO_V)) begin
      st_d.lineVolt = 8'h00;
    end else begin
      st_d.lineVolt = st_q.vSync2;
    end

    // current fields only carry meaning while the line side is off-hook
    if (lineOffHook) begin
      st_d.fine = st_q.iSync2;
      st_d.coarse = (coarseFull > 8'(line_sense_pkg::COARSE_MAX))
                    ? line_sense_pkg::COARSE_MAX
                    : coarseFull[4:0];
    end else begin
      st_d.fine = 8'h00;
      st_d.coarse = 5'h00;
    end
    st_d.overCur = st_q.fine > ocCode;
    st_d.dropout = lineOffHook && st_q.fine == 8'h00;

    // register writes; writing zero clears a flag, writing one keeps it
    if (regWrEn) begin
      case (regAddr)
        line_sense_pkg::REG_IRQ_CTL: begin
          st_d.irq_pin_enable = regWrData[line_sense_pkg::B_IRQ_PIN_ENABLE];
          st_d.irq_pin_polarity = regWrData[line_sense_pkg::B_IRQ_PIN_POLARITY];
        end
        line_sense_pkg::REG_IRQ_MASK: begin
          st_d.polarity_change_mask = regWrData[line_sense_pkg::B_POL];
          st_d.tip_ground_mask = regWrData[line_sense_pkg::B_TG];
          st_d.maxm = regWrData[line_sense_pkg::B_MAXI];
        end
        line_sense_pkg::REG_HOOK: begin
          st_d.hook = regWrData[line_sense_pkg::B_HOOK];
        end
        line_sense_pkg::REG_ADC_CAL: begin
          st_d.adc_cal_disable = regWrData[line_sense_pkg::B_ADC_CAL_DISABLE];
        end
        line_sense_pkg::REG_RES_CAL: begin
          st_d.resistor_cal_disable = regWrData[line_sense_pkg::B_RESISTOR_CAL_DISABLE];
        end
        line_sense_pkg::REG_DC_CTL: begin
          st_d.current_limit_mode = regWrData[line_sense_pkg::B_CURRENT_LIMIT_MODE];
        end
        line_sense_pkg::REG_SETTLE: begin
          st_d.offhook_settle_select = regWrData[line_sense_pkg::B_FOH_LO +: 2];
          st_d.low_voltage_zero_force_disable = regWrData[line_sense_pkg::B_LOW_VOLTAGE_ZERO_FORCE_DISABLE];
        end
        line_sense_pkg::REG_GND_START: begin
          st_d.ringGnd = regWrData[line_sense_pkg::B_RG];
          st_d.tipOpen = regWrData[line_sense_pkg::B_TIP_RELAY_OPEN];
        end
        default: begin
          st_d.rdData = st_d.rdData;
        end
      endcase
    end
    if (wrFlag) begin
      st_d.polFlag = st_q.polFlag & regWrData[line_sense_pkg::B_POL];
      st_d.tgFlag = st_q.tgFlag & regWrData[line_sense_pkg::B_TG];
      st_d.maxFlag = st_q.maxFlag & regWrData[line_sense_pkg::B_MAXI];
    end
    // hardware sets win over a same-cycle clear
    if (st_d.lineVolt[7] != st_q.lineVolt[7]) begin
      st_d.polFlag = 1'b1;
    end
    // onset taken past the second sync flop, never from the first
    if (st_q.tSync2 && !st_q.tipSeen) begin
      st_d.tgFlag = 1'b1;
    end
    if (st_d.coarse == line_sense_pkg::COARSE_MAX) begin
      st_d.maxFlag = 1'b1;
    end

    // off-hook sequence, counted in microsecond ticks
    if (tick && st_q.state != line_sense_pkg::ST_ONHOOK) begin
      st_d.cnt = st_q.cnt + CNT_W_L'(1);
    end
    case (st_q.state)
      line_sense_pkg::ST_ONHOOK: begin
        st_d.cnt = '0;
        if (st_q.hook) begin
          st_d.state = line_sense_pkg::ST_LATENCY;
        end
      end
      line_sense_pkg::ST_LATENCY, line_sense_pkg::ST_SETTLE,
      line_sense_pkg::ST_RCAL, line_sense_pkg::ST_ADCCAL: begin
        if (tick && st_q.cnt == target - CNT_W_L'(1)) begin
          st_d.cnt = '0;
          case (st_q.state)
            line_sense_pkg::ST_LATENCY: begin
              st_d.state = line_sense_pkg::ST_SETTLE;
            end
            line_sense_pkg::ST_SETTLE: begin
              if (!st_q.resistor_cal_disable) begin
                st_d.state = line_sense_pkg::ST_RCAL;
              end else if (!st_q.adc_cal_disable) begin
                st_d.state = line_sense_pkg::ST_ADCCAL;
              end else begin
                st_d.state = line_sense_pkg::ST_ACTIVE;
              end
            end
            line_sense_pkg::ST_RCAL: begin
              st_d.state = st_q.adc_cal_disable ? line_sense_pkg::ST_ACTIVE
                                     : line_sense_pkg::ST_ADCCAL;
            end
            default: st_d.state = line_sense_pkg::ST_ACTIVE;
          endcase
        end
      end
      line_sense_pkg::ST_ACTIVE: st_d.cnt = '0;
      default: st_d.state = line_sense_pkg::ST_ONHOOK;
    endcase
    if (!st_q.hook) begin
      st_d.state = line_sense_pkg::ST_ONHOOK;
      st_d.cnt = '0;
    end

    // read data registered one cycle after the strobe
    if (regRdEn) begin
      case (regAddr)
        line_sense_pkg::REG_IRQ_CTL: st_d.rdData = {st_q.irq_pin_enable, st_q.irq_pin_polarity,
                                                    6'h00};
        line_sense_pkg::REG_IRQ_MASK: st_d.rdData = {5'h00, st_q.maxm, st_q.tip_ground_mask,
                                                     st_q.polarity_change_mask};
        line_sense_pkg::REG_IRQ_FLAG: st_d.rdData = {5'h00, st_q.maxFlag,
                                                     st_q.tgFlag, st_q.polFlag};
        line_sense_pkg::REG_HOOK: st_d.rdData = {7'h00, st_q.hook};
        line_sense_pkg::REG_COARSE: st_d.rdData = {3'h0, st_q.coarse};
        line_sense_pkg::REG_ADC_CAL: st_d.rdData = {2'h0, st_q.adc_cal_disable, 5'h00};
        line_sense_pkg::REG_LINE_STAT: st_d.rdData = {6'h00, st_q.dropout,
                                                      st_q.overCur};
        line_sense_pkg::REG_RES_CAL: st_d.rdData = {2'h0, st_q.resistor_cal_disable, 5'h00};
        line_sense_pkg::REG_DC_CTL: st_d.rdData = {6'h00, st_q.current_limit_mode, 1'b0};
        line_sense_pkg::REG_FINE: st_d.rdData = st_q.fine;
        line_sense_pkg::REG_VOLT: st_d.rdData = st_q.lineVolt;
        line_sense_pkg::REG_SETTLE: st_d.rdData = {1'b0, st_q.offhook_settle_select, 4'h0,
                                                   st_q.low_voltage_zero_force_disable};
        line_sense_pkg::REG_GND_START: st_d.rdData = {5'h00, st_q.tSync2,
                                                      st_q.tipOpen,
                                                      st_q.ringGnd};
        default: st_d.rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.offhook_settle_select <= line_sense_pkg::FOH_RESET;
      st_q.ringGnd <= line_sense_pkg::RG_RESET;
      st_q.tipOpen <= line_sense_pkg::TIP_RELAY_OPEN_RESET;
      st_q.state <= line_sense_pkg::ST_ONHOOK;
    end else begin
      st_q <= st_d;
    end
  end

  // level stays while any enabled flag is set
  assign irqActive = st_q.irq_pin_enable && ((st_q.polFlag && st_q.polarity_change_mask) ||
                     (st_q.tgFlag && st_q.tip_ground_mask) ||
                     (st_q.maxFlag && st_q.maxm));
  // open drain: drive the active level only, the external resistor idles it
  assign irqOe = irqActive;
  assign irqOut = st_q.irq_pin_polarity;

  assign regRdData = st_q.rdData;
  assign lineOffHook = st_q.state != line_sense_pkg::ST_ONHOOK &&
                       st_q.state != line_sense_pkg::ST_LATENCY;
  assign txRxBlocked = st_q.state != line_sense_pkg::ST_ACTIVE;
  assign resCalActive = st_q.state == line_sense_pkg::ST_RCAL;
  assign adcCalActive = st_q.state == line_sense_pkg::ST_ADCCAL;
  assign tipRelayOpen = st_q.tipOpen;
  assign ringGroundRelayCtl = st_q.ringGnd;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence hookRequest;
    st_q.state == line_sense_pkg::ST_ONHOOK ##1
    st_q.state == line_sense_pkg::ST_LATENCY;
  endsequence

  polarity_flag_a: assert property (
    $changed(st_q.lineVolt[7]) |-> st_q.polFlag)
    else $error("polarity flag missed a sign change");
  force_zero_a: assert property (
    (!st_q.low_voltage_zero_force_disable && vMag <= 9'(line_sense_pkg::LV_ZERO_V)) |=>
    st_q.lineVolt == 8'h00)
    else $error("small voltage not forced to zero");
  polarity_irq_a: assert property (
    (st_q.irq_pin_enable && st_q.polarity_change_mask && $rose(st_q.polFlag)) |-> irqOe)
    else $error("polarity change raised no interrupt");
  irq_level_a: assert property (
    irqOe |-> irqOut == st_q.irq_pin_polarity)
    else $error("interrupt pin at wrong level");
  max_flag_a: assert property (
    st_q.coarse == line_sense_pkg::COARSE_MAX |-> st_q.maxFlag)
    else $error("max current flag not set");
  limit_overcur_a: assert property (
    (st_q.current_limit_mode && st_q.fine > line_sense_pkg::OC_LO_CODE) |=> st_q.overCur)
    else $error("overcurrent not flagged in limit mode");
  hook_latency_a: assert property (
    $rose(lineOffHook) |->
    $past(st_q.state) == line_sense_pkg::ST_LATENCY &&
    $past(st_q.cnt) == CNT_W_L'(LATENCY_US - 1))
    else $error("line side off-hook before latency");
  latency_start_a: assert property (
    hookRequest |-> st_q.cnt == '0 && !lineOffHook)
    else $error("latency count did not start from zero");
  tip_flag_a: assert property (
    $rose(st_q.tSync2) |=> st_q.tgFlag)
    else $error("tip ground flag not latched");
  traffic_open_a: assert property (
    st_q.state == line_sense_pkg::ST_ACTIVE |->
    !txRxBlocked && $past(st_q.hook))
    else $error("traffic blocked while active");
endmodule

//--- host_link_model.sv
// host model issuing register accesses on the control link
`timescale 1ns/1ps
module host_link_model (
  // clock
  input wire logic core_clk,
  // register strobes and data
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn,
  input wire logic [7:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end
  // strobes last one edge; address and data are inverted afterwards
  // so that a stale value never passes for a valid one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge core_clk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge core_clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask
  // flags clear on a written zero, ones leave the others alone
  task automatic clear_flags(input logic [2:0] keep);
    wr(line_sense_pkg::REG_IRQ_FLAG, {5'h00, keep});
  endtask
  task automatic gs_idle();
    wr(line_sense_pkg::REG_GND_START, 8'h01);
  endtask
  task automatic seize();
    wr(line_sense_pkg::REG_GND_START, 8'h00);
  endtask
endmodule

//--- tb.sv
// self-checking bench for line sense and hook control
`timescale 1ns/1ps
module tb;
  localparam int LAT = 4;
  localparam int MSU = 2;
  localparam logic [7:0] C_TAB [8] = '{8'h00, 8'h0C, 8'h0D, 8'h5D,
                                       8'h91, 8'h92, 8'h36, 8'h37};
  logic core_clk, rst, regWrEn, regRdEn, tipCurrentDetect;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [7:0] lineVoltSample, loopCurrentSample;
  logic lineOffHook, txRxBlocked, resCalActive, adcCalActive;
  logic tipRelayOpen, ringGroundRelayCtl, irqOut, irqOe;
  logic pol, tg, mx, lastSign;
  logic [7:0] ctl, mask, rd, e;
  int num_errors, comparisons, seed, n;

  line_sense_hook_control #(.TICK_CYCLES(1), .LATENCY_US(LAT),
    .MS_US(MSU)) i_line_sense_hook_control (.core_clk(core_clk),
    .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .lineVoltSample(lineVoltSample),
    .loopCurrentSample(loopCurrentSample),
    .tipCurrentDetect(tipCurrentDetect), .lineOffHook(lineOffHook),
    .txRxBlocked(txRxBlocked), .resCalActive(resCalActive),
    .adcCalActive(adcCalActive), .tipRelayOpen(tipRelayOpen),
    .ringGroundRelayCtl(ringGroundRelayCtl), .irqOut(irqOut),
    .irqOe(irqOe));
  host_link_model i_host_link_model (.core_clk(core_clk),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    i_host_link_model.wr(a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
    i_host_link_model.rd(a, rd);
    check(rd, x);
  endtask
  // irq pin level only counts while the pin is driven
  task automatic flagchk();
    logic oe;
    logic [7:0] f;
    oe = ctl[7] && ((mask[2:0] & {mx, tg, pol}) != 3'h0);
    f = {5'h0, mx, tg, pol};
    rdchk(line_sense_pkg::REG_IRQ_FLAG, f);
    f = {6'h0, oe, oe & ctl[6]};
    check({6'h0, irqOe, irqOe & irqOut}, f);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return lineOffHook;
      1: return resCalActive;
      2: return adcCalActive;
      default: return !txRxBlocked;
    endcase
  endfunction
  task automatic wait_for(input int s, input int lim);
    n = 0;
    while (sig(s) !== 1'b1 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      $display("Error at %0t: wait %0d ran out", $time, s);
      report_and_stop();
    end
  endtask
  // phase edges may slip by a tick, so allow a small window
  task automatic win(input int t);
    check(8'(n + 3 >= t && n <= t + 3), 8'h01);
  endtask

  task automatic volt_test(input logic lv);
    logic [7:0] v;
    // park the line at 0 V so a change of forcing cannot flip the sign
    lineVoltSample = 8'h00;
    if (lastSign) pol = 1'b1;
    lastSign = 1'b0;
    w(line_sense_pkg::REG_SETTLE, {1'b0, 2'h1, 4'h0, lv});
    ctl = 8'h80;
    mask = 8'h01;
    w(line_sense_pkg::REG_IRQ_CTL, ctl);
    w(line_sense_pkg::REG_IRQ_MASK, mask);
    for (int i = 0; i < 32; i++) begin
      v = (i % 4 == 0) ? 8'(i / 4 - 4) : 8'($random(seed));
      @(negedge core_clk);
      lineVoltSample = v;
      repeat (4) @(negedge core_clk);
      e = (!lv && $signed(v) >= -3 && $signed(v) <= 3) ? 8'h00 : v;
      if (e[7] != lastSign) pol = 1'b1;
      lastSign = e[7];
      rdchk(line_sense_pkg::REG_VOLT, e);
      flagchk();
      if (i == 16) begin
        ctl = 8'hC0;
        w(line_sense_pkg::REG_IRQ_CTL, ctl);
        pol = 1'b0;
        i_host_link_model.clear_flags(3'b110);
      end
    end
    $display("test voltage done");
  endtask

  task automatic cur_test();
    logic [7:0] c, k;
    mask = 8'h04;
    w(line_sense_pkg::REG_IRQ_MASK, mask);
    for (int i = 0; i < 24; i++) begin
      c = i < 8 ? C_TAB[i] : 8'($random(seed));
      if (i == 12) w(line_sense_pkg::REG_DC_CTL, 8'h02);
      @(negedge core_clk);
      loopCurrentSample = c;
      repeat (4) @(negedge core_clk);
      k = c / 3 > 31 ? 8'h1F : 8'(c / 3);
      if (k == 8'h1F) mx = 1'b1;
      rdchk(line_sense_pkg::REG_FINE, c);
      rdchk(line_sense_pkg::REG_COARSE, k);
      e = {6'h0, c == 8'h00, c > (i < 12 ? 145 : 54)};
      rdchk(line_sense_pkg::REG_LINE_STAT, e);
      flagchk();
    end
    // a mid-range current keeps later phases free of new flags
    loopCurrentSample = 8'h30;
    w(line_sense_pkg::REG_DC_CTL, 8'h00);
    mx = 1'b0;
    i_host_link_model.clear_flags(3'b011);
    flagchk();
    $display("test current done");
  endtask

  task automatic hook_seq(input logic [1:0] sel, input logic rc, ac, cur);
    int t;
    w(line_sense_pkg::REG_SETTLE, {1'b0, sel, 4'h0, 1'b1});
    w(line_sense_pkg::REG_RES_CAL, {2'h0, rc, 5'h00});
    w(line_sense_pkg::REG_ADC_CAL, {2'h0, ac, 5'h00});
    w(line_sense_pkg::REG_HOOK, 8'h01);
    wait_for(0, LAT + 8);
    win(LAT);
    check({7'h0, txRxBlocked}, 8'h01);
    t = sel == 2'h0 ? 512 : sel == 2'h1 ? 128 : sel == 2'h2 ? 64 : 8;
    t = t * MSU;
    if (!rc) begin
      wait_for(1, t + 8);
      win(t);
      t = 17 * MSU;
    end
    if (!ac) begin
      wait_for(2, t + 8);
      win(t);
      t = 256 * MSU;
    end
    wait_for(3, t + 8);
    win(t);
    if (cur) cur_test();
    w(line_sense_pkg::REG_HOOK, 8'h00);
    // the state follows the hook register one cycle later
    @(negedge core_clk);
    check({7'h0, lineOffHook}, 8'h00);
    rdchk(line_sense_pkg::REG_FINE, 8'h00);
    $display("test hook sequence done");
  endtask

  task automatic gs_test();
    ctl = 8'h80;
    mask = 8'h02;
    w(line_sense_pkg::REG_IRQ_CTL, ctl);
    w(line_sense_pkg::REG_IRQ_MASK, mask);
    i_host_link_model.gs_idle();
    check({6'h0, tipRelayOpen, ringGroundRelayCtl}, 8'h01);
    i_host_link_model.seize();
    check({6'h0, tipRelayOpen, ringGroundRelayCtl}, 8'h00);
    flagchk();
    tipCurrentDetect = 1'b1;
    tg = 1'b1;
    repeat (4) @(negedge core_clk);
    rdchk(line_sense_pkg::REG_GND_START, 8'h04);
    flagchk();
    tipCurrentDetect = 1'b0;
    repeat (4) @(negedge core_clk);
    rdchk(line_sense_pkg::REG_GND_START, 8'h00);
    flagchk();
    tg = 1'b0;
    i_host_link_model.clear_flags(3'b101);
    flagchk();
    w(line_sense_pkg::REG_GND_START, 8'h02);
    check({6'h0, tipRelayOpen, ringGroundRelayCtl}, 8'h02);
    $display("test ground start done");
  endtask

  initial begin
    seed = 43;
    rst = 1'b1;
    lineVoltSample = 8'h00;
    loopCurrentSample = 8'h00;
    tipCurrentDetect = 1'b0;
    {pol, tg, mx, lastSign} = 4'h0;
    ctl = 8'h00;
    mask = 8'h00;
    num_errors = 0;
    comparisons = 0;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    check({5'h0, lineOffHook, txRxBlocked, irqOe}, 8'h02);
    rdchk(line_sense_pkg::REG_SETTLE, 8'h20);
    rdchk(line_sense_pkg::REG_GND_START, 8'h00);
    lineVoltSample = 8'h40;
    w(line_sense_pkg::REG_VOLT, 8'h55);
    lastSign = 1'b0;
    rdchk(line_sense_pkg::REG_VOLT, 8'h40);
    rdchk(8'hFF, 8'h00);
    $display("test reset done");
    volt_test(1'b0);
    volt_test(1'b1);
    hook_seq(2'h1, 1'b0, 1'b0, 1'b1);
    hook_seq(2'h0, 1'b1, 1'b0, 1'b0);
    hook_seq(2'h2, 1'b0, 1'b1, 1'b0);
    hook_seq(2'h3, 1'b1, 1'b1, 1'b0);
    gs_test();
    report_and_stop();
  end
endmodule
